// >>> rsw_top.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`include "rsw_regs.svh"
module rsw_top #(
  parameter int WDT_BASE_CYC = `RSW_CYC_DN(`RSW_T_WDT_NS)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input wire rsw_pkg::rsw_axi_req_t axi_req,
  output rsw_pkg::rsw_axi_rsp_t axi_rsp,
  // Reset sources and supply
  input wire logic ext_reset_pin_n,
  input wire logic power_on_brownout_reset_n,
  input wire logic supply_ok,
  input wire logic [2:0] flash_thr,
  // Low-speed sources
  input wire logic lsrc_rc,
  input wire logic lsrc_xtal,
  input wire logic lsclk_crystal_in_pin,
  input wire logic lsrc_rc_running,
  // Power state
  input wire logic sleep,
  input wire logic dbg_stall,
  // Power-up controls
  output logic hsosc_en,
  output logic core_reg_en,
  output logic nvm_init,
  output logic cpu_rst_n,
  output logic periph_rst_n,
  // Supply monitor
  output logic [2:0] supply_monitor_thr,
  output logic supply_monitor_en,
  output logic supply_monitor_irq,
  // Watchdog and status
  output logic wdt_exc,
  output logic ram_invalid,
  // Low-speed clock
  output logic lsclk,
  output logic [15:0] lsclk_cal
);

  ////////////////////////////////////////////////////////////////////////////

  localparam logic [15:0] C_OSC = 16'(`RSW_CYC_UP(`RSW_T_OSC_NS));
  localparam logic [15:0] C_REG = 16'(`RSW_CYC_UP(`RSW_T_REG_NS));
  localparam logic [15:0] C_NVM = 16'(`RSW_CYC_UP(`RSW_T_NVM_NS));
  localparam logic [15:0] C_SVM = 16'(`RSW_CYC_UP(`RSW_T_SVM_NS));

  if (`RSW_CYC_UP(`RSW_T_NVM_NS) > 65535 || WDT_BASE_CYC < 1) begin : g_chk
    $error("rsw_top: timing counts out of range");
  end

  localparam rsw_pkg::rsw_cfg_t CFG_RST = '{
    lsel: `RSW_LSEL_RC,
    cal: `RSW_CAL_RST,
    svm_thr: `RSW_SVM_THR_RST,
    svm_en: 1'b1,
    svm_mode: `RSW_SVM_MODE_RST,
    wdt_en: 1'b1,
    wdt_exc: 1'b0,
    wdt_presc: `RSW_WDT_PRESC_MAX
  };

  typedef struct packed {
    rsw_pkg::rsw_seq_t seq;
    logic [15:0] tmr;
    rsw_pkg::rsw_cfg_t cfg;
    logic osc_en;
    logic reg_en;
    logic nvm_init;
    logic rel;
    logic kick;
    logic swreq;
    logic wdt_flag;
    logic ram_inv;
    logic sleep_q;
    logic sup_q;
    logic svm_irq;
    logic wdt_exc;
    logic lsclk;
    logic aw_have;
    logic w_have;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    rsw_pkg::rsw_axi_rsp_t rsp;
  } rsw_st_t;

  function automatic rsw_st_t st_rst();
    rsw_st_t s;
    s = '0;
    s.seq = rsw_pkg::SEQ_HOLD;
    s.cfg = CFG_RST;
    s.ram_inv = 1'b1;
    s.sup_q = 1'b1;
    s.rsp.awready = 1'b1;
    s.rsp.wready = 1'b1;
    s.rsp.arready = 1'b1;
    return s;
  endfunction

  localparam rsw_st_t ST_RST = st_rst();

  // Bit 3 flags a mapped word; low bits give its index
  function automatic logic [3:0] dec(input logic [31:0] a);
    logic ok;
    ok = (a[31:5] == 27'h0) && (a[1:0] == 2'h0) &&
         (a[4:2] <= `RSW_A_STATUS);
    return {ok, a[4:2]};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  rsw_st_t q, d;
  logic wdt_expire;
  logic wdt_run;

  assign wdt_run = q.rel && q.cfg.wdt_en && !sleep && !dbg_stall;

  rsw_wdt #(
    .BASE_CYC(WDT_BASE_CYC),
    .PRESC_MAX(int'(`RSW_WDT_PRESC_MAX))
  ) u_wdt (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(wdt_run),
    .restart(q.kick),
    .presc(q.cfg.wdt_presc),
    .expire(wdt_expire)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [3:0] wa;
    logic [3:0] ra;
    logic [31:0] cur;
    logic [31:0] wm;
    logic chip_rst;
    logic pins_ok;
    wa = dec(q.awaddr);
    ra = dec(axi_req.araddr);
    cur = 32'h0;
    wm = 32'h0;
    chip_rst = 1'b0;
    pins_ok = ext_reset_pin_n && power_on_brownout_reset_n;
    d = q;
    d.kick = 1'b0;
    d.svm_irq = 1'b0;
    d.wdt_exc = 1'b0;
    d.sleep_q = sleep;
    d.sup_q = supply_ok;

    // Write channel capture, either order
    if (axi_req.awvalid && q.rsp.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      d.w_have = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end

    // Perform the write once both halves are held
    if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = wa[3] ? `RSW_RESP_OKAY : `RSW_RESP_DECERR;
      case (wa[2:0])
        `RSW_A_LSCLK: begin
          cur = {30'h0, q.cfg.lsel};
          wm = wmerge(cur, q.wdata, q.wstrb);
          // Choice sticks until chip reset
          if (wa[3] && q.cfg.lsel == `RSW_LSEL_RC &&
              wm[1:0] != `RSW_LSEL_BAD) begin
            d.cfg.lsel = wm[1:0];
          end
        end
        `RSW_A_CAL: begin
          cur = {16'h0, q.cfg.cal};
          wm = wmerge(cur, q.wdata, q.wstrb);
          if (wa[3]) begin
            d.cfg.cal = wm[15:0];
          end
        end
        `RSW_A_SVM: begin
          cur = {25'h0, q.cfg.svm_mode, q.cfg.svm_en, 1'b0,
                 q.cfg.svm_thr};
          wm = wmerge(cur, q.wdata, q.wstrb);
          if (wa[3]) begin
            d.cfg.svm_thr = wm[2:0];
            d.cfg.svm_en = wm[`RSW_SVM_EN_BIT];
            d.cfg.svm_mode = wm[`RSW_SVM_MODE_LSB +: 2];
          end
        end
        `RSW_A_WDT: begin
          cur = {26'h0, q.cfg.wdt_exc, q.cfg.wdt_en, q.cfg.wdt_presc};
          wm = wmerge(cur, q.wdata, q.wstrb);
          if (wa[3]) begin
            if (wm[3:0] <= `RSW_WDT_PRESC_MAX) begin
              d.cfg.wdt_presc = wm[3:0];
            end
            d.cfg.wdt_en = wm[`RSW_WDT_EN_BIT];
            d.cfg.wdt_exc = wm[`RSW_WDT_EXC_BIT];
          end
        end
        `RSW_A_KICK: begin
          if (wa[3]) begin
            d.kick = 1'b1;
          end
        end
        `RSW_A_SWRST: begin
          wm = wmerge(32'h0, q.wdata, q.wstrb);
          if (wa[3] && wm[0]) begin
            d.swreq = 1'b1;
          end
        end
        `RSW_A_STATUS: begin
          wm = wmerge(32'h0, q.wdata, q.wstrb);
          if (wa[3] && wm[`RSW_ST_WDT_BIT]) begin
            d.wdt_flag = 1'b0;
          end
          if (wa[3] && wm[`RSW_ST_RAM_BIT]) begin
            d.ram_inv = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Read channel
    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = ra[3] ? `RSW_RESP_OKAY : `RSW_RESP_DECERR;
      d.rsp.rdata = 32'h0;
      if (ra[3]) begin
        case (ra[2:0])
          `RSW_A_LSCLK: d.rsp.rdata = {30'h0, q.cfg.lsel};
          `RSW_A_CAL: d.rsp.rdata = {16'h0, q.cfg.cal};
          `RSW_A_SVM: begin
            d.rsp.rdata = {25'h0, q.cfg.svm_mode, q.cfg.svm_en, 1'b0,
                           q.cfg.svm_thr};
          end
          `RSW_A_WDT: begin
            d.rsp.rdata = {26'h0, q.cfg.wdt_exc, q.cfg.wdt_en,
                           q.cfg.wdt_presc};
          end
          `RSW_A_STATUS: begin
            d.rsp.rdata[`RSW_ST_WDT_BIT] = q.wdt_flag;
            d.rsp.rdata[`RSW_ST_RAM_BIT] = q.ram_inv;
            d.rsp.rdata[`RSW_ST_SUP_BIT] = supply_ok;
            d.rsp.rdata[`RSW_ST_RCRUN_BIT] = lsrc_rc_running;
            d.rsp.rdata[`RSW_ST_LOCK_BIT] =
              (q.cfg.lsel != `RSW_LSEL_RC);
          end
          default: d.rsp.rdata = 32'h0;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequencer

    case (q.seq)
      rsw_pkg::SEQ_HOLD: begin
        if (pins_ok) begin
          d.seq = rsw_pkg::SEQ_OSC;
          d.osc_en = 1'b1;
          d.tmr = C_OSC;
        end
      end
      rsw_pkg::SEQ_OSC: begin
        if (q.tmr == 16'h0) begin
          d.seq = rsw_pkg::SEQ_SUPPLY;
        end else begin
          d.tmr = q.tmr - 16'h1;
        end
      end
      rsw_pkg::SEQ_SUPPLY: begin
        // Threshold here is still the reset default
        if (supply_ok) begin
          d.reg_en = 1'b1;
          d.seq = rsw_pkg::SEQ_REG;
          d.tmr = C_REG;
        end
      end
      rsw_pkg::SEQ_REG: begin
        if (q.tmr == 16'h0) begin
          d.seq = rsw_pkg::SEQ_NVM;
          d.nvm_init = 1'b1;
          d.tmr = C_NVM;
        end else begin
          d.tmr = q.tmr - 16'h1;
        end
      end
      rsw_pkg::SEQ_NVM: begin
        if (q.tmr == 16'h0) begin
          d.seq = rsw_pkg::SEQ_SVM;
          d.nvm_init = 1'b0;
          d.cfg.svm_thr = flash_thr;
          d.tmr = C_SVM;
        end else begin
          d.tmr = q.tmr - 16'h1;
        end
      end
      rsw_pkg::SEQ_SVM: begin
        if (q.tmr != 16'h0) begin
          d.tmr = q.tmr - 16'h1;
        end else if (supply_ok) begin
          d.seq = rsw_pkg::SEQ_RUN;
          d.rel = 1'b1;
          d.kick = 1'b1;
        end else begin
          // Stay in reset and recheck after another pause
          d.tmr = C_SVM;
        end
      end
      rsw_pkg::SEQ_RUN: begin
        if (q.swreq) begin
          chip_rst = 1'b1;
          d.ram_inv = 1'b1;
        end
        if (wdt_expire && !q.cfg.wdt_exc) begin
          chip_rst = 1'b1;
          d.wdt_flag = 1'b1;
        end
        if (wdt_expire && q.cfg.wdt_exc) begin
          d.wdt_exc = 1'b1;
        end
        // Monitor only acts while awake or dozing
        if (q.cfg.svm_en && !sleep) begin
          if (q.cfg.svm_mode == `RSW_SVM_MODE_RST && !supply_ok) begin
            chip_rst = 1'b1;
          end
          if (q.cfg.svm_mode == `RSW_SVM_MODE_FALL &&
              q.sup_q && !supply_ok) begin
            d.svm_irq = 1'b1;
          end
          if (q.cfg.svm_mode == `RSW_SVM_MODE_RISE &&
              !q.sup_q && supply_ok) begin
            d.svm_irq = 1'b1;
          end
        end
        if (q.sleep_q && !sleep) begin
          d.cfg.wdt_en = 1'b1;
          d.cfg.wdt_presc = `RSW_WDT_PRESC_MAX;
          d.kick = 1'b1;
        end
      end
      default: begin
        d.seq = rsw_pkg::SEQ_HOLD;
      end
    endcase

    // Any reset source restarts the whole sequence with defaults
    if (chip_rst || !pins_ok) begin
      d.seq = rsw_pkg::SEQ_HOLD;
      d.cfg = CFG_RST;
      d.rel = 1'b0;
      d.reg_en = 1'b0;
      d.nvm_init = 1'b0;
      d.osc_en = pins_ok;
      d.swreq = 1'b0;
      d.kick = 1'b0;
    end

    // Low-speed clock source
    case (q.cfg.lsel)
      `RSW_LSEL_XTAL: d.lsclk = lsrc_xtal;
      `RSW_LSEL_EXT: d.lsclk = lsclk_crystal_in_pin;
      default: d.lsclk = lsrc_rc;
    endcase

    d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
    d.rsp.wready = !d.w_have && !d.rsp.bvalid;
    d.rsp.arready = !d.rsp.rvalid;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign axi_rsp = q.rsp;
  assign hsosc_en = q.osc_en;
  assign core_reg_en = q.reg_en;
  assign nvm_init = q.nvm_init;
  assign cpu_rst_n = q.rel;
  assign periph_rst_n = q.rel;
  assign supply_monitor_thr = q.cfg.svm_thr;
  assign supply_monitor_en = q.cfg.svm_en;
  assign supply_monitor_irq = q.svm_irq;
  assign wdt_exc = q.wdt_exc;
  assign ram_invalid = q.ram_inv;
  assign lsclk = q.lsclk;
  assign lsclk_cal = q.cfg.cal;
endmodule // rsw_top

// >>> rsw_regs.svh
// Function
// - Low-speed clock: RC, crystal or external source
// - Defaults to RC; other choice locked until reset
// - Software calibration factor applied to RC timing; here it is only held and driven out on lsclk_cal
// - External source taken straight from crystal-input pin
// - Enable oscillators, wait 13us for RC start
// - Regulators on only when supply above default threshold
// - Wait 15us regulators, then 150us memory init
// - Apply loaded threshold, wait 2.5us, recheck, release
// - Hold internal reset until stabilisation interval elapses
// - Reassert reset when supply falls below POR threshold
// - Held in reset while pin low; restart on rise
// - Software reset request gives full chip reset
// - Supply monitor: reset, or interrupt on fall/rise
// - Monitor enabled at power-up, extends power-up reset
// - Eight selectable thresholds; flash value, 2.0V default
// - Watchdog counts RC clock through prescaler, 8ms-16.4s; here it counts mclk cycles
// - Watchdog expiry resets chip and sets cause flag
// - Watchdog may raise exception instead of reset
// - Watchdog enabled, longest period after reset or wake
// - Watchdog runs in doze, stops sleep/debug, resumes
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH

// Timing, in ns
`define RSW_CLK_NS 50
`define RSW_T_OSC_NS 13000
`define RSW_T_REG_NS 15000
`define RSW_T_NVM_NS 150000
`define RSW_T_SVM_NS 2500
`define RSW_T_WDT_NS 8000000
`define RSW_CYC_UP(t) (((t) + `RSW_CLK_NS - 1) / `RSW_CLK_NS)
`define RSW_CYC_DN(t) ((t) / `RSW_CLK_NS)

// Register word indices (byte offset / 4)
`define RSW_A_LSCLK 3'h0
`define RSW_A_CAL 3'h1
`define RSW_A_SVM 3'h2
`define RSW_A_WDT 3'h3
`define RSW_A_KICK 3'h4
`define RSW_A_SWRST 3'h5
`define RSW_A_STATUS 3'h6

// Field positions
`define RSW_SVM_EN_BIT 4
`define RSW_SVM_MODE_LSB 5
`define RSW_WDT_EN_BIT 4
`define RSW_WDT_EXC_BIT 5
`define RSW_ST_WDT_BIT 0
`define RSW_ST_RAM_BIT 1
`define RSW_ST_SUP_BIT 2
`define RSW_ST_RCRUN_BIT 3
`define RSW_ST_LOCK_BIT 4

// Encodings and reset values
`define RSW_LSEL_RC 2'h0
`define RSW_LSEL_XTAL 2'h1
`define RSW_LSEL_EXT 2'h2
`define RSW_LSEL_BAD 2'h3
`define RSW_SVM_THR_RST 3'h1
`define RSW_SVM_MODE_RST 2'h0
`define RSW_SVM_MODE_FALL 2'h1
`define RSW_SVM_MODE_RISE 2'h2
`define RSW_CAL_RST 16'h0000
`define RSW_WDT_PRESC_MAX 4'hb
`define RSW_RESP_OKAY 2'h0
`define RSW_RESP_DECERR 2'h3

`endif

// >>> rsw_pkg.sv
package rsw_pkg;

  typedef enum logic [2:0] {
    SEQ_HOLD, SEQ_OSC, SEQ_SUPPLY, SEQ_REG, SEQ_NVM, SEQ_SVM, SEQ_RUN
  } rsw_seq_t;

  typedef struct packed {
    logic [1:0] lsel;
    logic [15:0] cal;
    logic [2:0] svm_thr;
    logic svm_en;
    logic [1:0] svm_mode;
    logic wdt_en;
    logic wdt_exc;
    logic [3:0] wdt_presc;
  } rsw_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } rsw_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsw_axi_rsp_t;

endpackage

// >>> rsw_wdt.sv
`timescale 1ns/10ps
module rsw_wdt #(
  parameter int BASE_CYC = 160000,
  parameter int PRESC_MAX = 11
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [3:0] presc,
  // Event
  output logic expire
);
  localparam int BW = $clog2(BASE_CYC + 1);
  localparam int CW = PRESC_MAX + 1;
  localparam logic [BW-1:0] BASE_LAST = BW'(BASE_CYC - 1);

  if (BASE_CYC < 1 || PRESC_MAX > 15) begin : g_chk
    $error("rsw_wdt: unsupported parameters");
  end

  typedef struct packed {
    logic [BW-1:0] base;
    logic [CW-1:0] cnt;
    logic expire;
  } wst_t;

  wst_t q, d;
  logic [CW-1:0] lim;

  always_comb begin
    lim = CW'((CW'(1) << presc) - CW'(1));
    d = q;
    d.expire = 1'b0;
    if (restart) begin
      d.base = '0;
      d.cnt = '0;
    end else if (run) begin
      if (q.base == BASE_LAST) begin
        d.base = '0;
        if (q.cnt >= lim) begin
          d.cnt = '0;
          d.expire = 1'b1;
        end else begin
          d.cnt = q.cnt + CW'(1);
        end
      end else begin
        d.base = q.base + BW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.expire;
endmodule // rsw_wdt

// >>> rsw_ext_reset_model.sv
`timescale 1ns/10ps
module rsw_ext_reset_model #(
  parameter int MIN_LOW = 3
) (
  // Clock
  input wire logic mclk,
  // Request from the bench
  input wire logic hold_low,
  // Reset pin
  output logic ext_reset_pin_n
);
  int cnt = 0;
  // Pull-up keeps the released pin high
  initial ext_reset_pin_n = 1'b1;
  // A short request is stretched to the minimum width
  always @(posedge mclk) begin
    if (hold_low) begin
      ext_reset_pin_n <= 1'b0;
      cnt <= MIN_LOW - 1;
    end else if (cnt > 0) begin
      ext_reset_pin_n <= 1'b0;
      cnt <= cnt - 1;
    end else begin
      ext_reset_pin_n <= 1'b1;
    end
  end
endmodule // rsw_ext_reset_model

// >>> rsw_assertions.sv
`timescale 1ns/10ps
module rsw_assertions #(
  parameter int WDT_BASE_CYC = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire logic ext_reset_pin_n,
  input wire logic power_on_brownout_reset_n,
  input wire logic supply_ok,
  input wire logic lsrc_rc,
  // Outputs
  input wire logic hsosc_en,
  input wire logic core_reg_en,
  input wire logic nvm_init,
  input wire logic cpu_rst_n,
  input wire logic supply_monitor_en,
  input wire logic supply_monitor_irq,
  input wire logic wdt_exc,
  input wire logic lsclk
);
  localparam int OSC_CYC = 260;
  localparam int BOOT_CYC = 3610;
  logic [12:0] osc_q;
  logic [12:0] boot_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Saturating, so a long supply wait cannot wrap into a false early release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 13'h0;
      boot_q <= 13'h0;
    end else begin
      osc_q <= !(hsosc_en && !core_reg_en) ? 13'h0 :
        osc_q + {12'h0, osc_q != 13'h1fff};
      boot_q <= !(hsosc_en && !cpu_rst_n) ? 13'h0 :
        boot_q + {12'h0, boot_q != 13'h1fff};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_regs_on;
    $rose(core_reg_en);
  endsequence
  sequence s_released;
    $rose(cpu_rst_n);
  endsequence
  a_osc_start_wait: assert property (s_regs_on |-> osc_q >= OSC_CYC)
    else $error("regulators on before oscillator wait");
  a_reg_need_supply: assert property (s_regs_on |-> $past(supply_ok))
    else $error("regulators on with supply low");
  a_nvm_after_reg: assert property
    ($rose(nvm_init) |-> $past(core_reg_en, 299))
    else $error("memory wait began early");
  a_release_recheck: assert property
    (s_released |-> $past(supply_ok) && !$past(nvm_init, 49))
    else $error("release without supply recheck");
  a_boot_interval: assert property (s_released |-> boot_q >= BOOT_CYC)
    else $error("release before start-up interval");
  a_por_holds: assert property
    (!power_on_brownout_reset_n |=> !cpu_rst_n)
    else $error("cpu ran during power-on reset");
  a_pin_holds: assert property
    (!ext_reset_pin_n |=> !cpu_rst_n && !hsosc_en)
    else $error("cpu ran with reset pin low");
  a_irq_one_cycle: assert property
    (supply_monitor_irq |=> !supply_monitor_irq)
    else $error("monitor interrupt longer than one cycle");
  a_mon_default: assert property (s_released |-> supply_monitor_en)
    else $error("monitor disabled at release");
  a_exc_pulse: assert property (wdt_exc |-> cpu_rst_n ##1 !wdt_exc)
    else $error("watchdog exception not a single pulse");
  a_lsclk_default: assert property ($past(rst_n) && !cpu_rst_n &&
    !$past(cpu_rst_n, 2) |-> lsclk == $past(lsrc_rc))
    else $error("low-speed clock not from rc in reset");
endmodule // rsw_assertions

// >>> test_reset_supervisor_watchdog_lsclk.sv
`timescale 1ns/10ps
module test_reset_supervisor_watchdog_lsclk;
  localparam logic [31:0] A_LS = 32'h0, A_CAL = 32'h4, A_SVM = 32'h8;
  localparam logic [31:0] A_WDT = 32'hc, A_KICK = 32'h10;
  localparam logic [31:0] A_SWR = 32'h14, A_ST = 32'h18;
  logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b1, sup = 1'b0, slp = 1'b0;
  logic dbg = 1'b0, hold = 1'b0, pin_n, hs, reg_en, nvm, cpu_n, per_n;
  logic mon_en, irq, exc, ram, ls, rc_run = 1'b1;
  logic [2:0] fthr = 3'h0, src = 3'h0, src_d = 3'h0, thr;
  logic [15:0] cal;
  logic [31:0] d;
  logic [1:0] r;
  int seed = 97, fail_count = 0, compares = 0, exc_n = 0;
  rsw_pkg::rsw_axi_req_t req = '0;
  rsw_pkg::rsw_axi_rsp_t rsp;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    src <= 3'($random(seed));
    src_d <= src;
    if (exc === 1'b1) exc_n <= exc_n + 1;
  end
  rsw_top #(.WDT_BASE_CYC(4)) u_rsw_top (.mclk(clk), .rst_n(rst_n),
    .axi_req(req), .axi_rsp(rsp), .ext_reset_pin_n(pin_n),
    .power_on_brownout_reset_n(por_n), .supply_ok(sup), .flash_thr(fthr),
    .lsrc_rc(src[2]), .lsrc_xtal(src[1]), .lsclk_crystal_in_pin(src[0]),
    .lsrc_rc_running(rc_run), .sleep(slp), .dbg_stall(dbg), .hsosc_en(hs),
    .core_reg_en(reg_en), .nvm_init(nvm), .cpu_rst_n(cpu_n),
    .periph_rst_n(per_n), .supply_monitor_thr(thr),
    .supply_monitor_en(mon_en), .supply_monitor_irq(irq), .wdt_exc(exc),
    .ram_invalid(ram), .lsclk(ls), .lsclk_cal(cal));
  rsw_ext_reset_model u_rsw_ext_reset_model (.mclk(clk), .hold_low(hold),
    .ext_reset_pin_n(pin_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, dat);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= dat;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [31:0] a, exp);
    rd(a);
    check(d, exp);
    check(32'(r), 32'h0);
  endtask
  function automatic logic sel(input int w);
    logic [2:0] s;
    s = {exc, irq, cpu_n};
    return s[w];
  endfunction
  // Bounded wait for cpu reset, monitor pulse or exception pulse
  task automatic await(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (sel(w) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(32'(sel(w)), 32'(v));
  endtask
  task automatic ls_chk(input int s);
    repeat (4) begin
      @(posedge clk);
      check(32'(ls), 32'(src_d[2 - s]));
    end
  endtask
  function automatic logic [31:0] svm_w(input logic [1:0] m);
    return {25'h0, m, 1'b1, 1'b0, fthr};
  endfunction
  function automatic logic [31:0] wdt_w(input logic [3:0] p, input logic e);
    return {26'h0, e, 1'b1, p};
  endfunction
  task automatic test_done;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    fail_count++;
    test_done;
  end
  initial begin
    fthr = 3'($random(seed));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4000) @(posedge clk);
    check(32'({cpu_n, reg_en}), 32'h0);
    sup <= 1'b1;
    await(0, 1'b1, 4000);
    check(32'(thr), 32'(fthr));
    rchk(A_SVM, svm_w(2'h0));
    rchk(A_WDT, wdt_w(4'hb, 1'b0));
    wr(A_WDT, wdt_w(4'hf, 1'b0));
    rchk(A_WDT, wdt_w(4'hb, 1'b0));
    rchk(A_ST, 32'he);
    rc_run <= 1'b0;
    rchk(A_ST, 32'h6);
    rc_run <= 1'b1;
    wr(32'h40, 32'h1);
    check(32'(r), 32'h3);
    rd(32'h40);
    check(d, 32'h0);
    check(32'(r), 32'h3);
    $display("test boot done");
    wr(A_LS, 32'h3);
    rchk(A_LS, 32'h0);
    for (int s = 0; s < 3; s++) begin
      wr(A_LS, s);
      rchk(A_LS, s == 2 ? 1 : s);
      ls_chk(s == 2 ? 1 : s);
    end
    rchk(A_ST, 32'h1e);
    d = 32'($random(seed) & 32'hffff);
    wr(A_CAL, d);
    check(32'(cal), d);
    wr(A_SWR, 32'h1);
    await(0, 1'b0, 10);
    await(0, 1'b1, 5000);
    check(32'(ram), 32'h1);
    rchk(A_LS, 32'h0);
    wr(A_ST, 32'h2);
    wr(A_LS, 32'h2);
    ls_chk(2);
    $display("test lsclk done");
    wr(A_WDT, wdt_w(4'h6, 1'b0));
    repeat (5) begin
      repeat (150) @(posedge clk);
      wr(A_KICK, 32'h1);
    end
    repeat (240) @(posedge clk);
    check(32'(cpu_n), 32'h1);
    await(0, 1'b0, 40);
    await(0, 1'b1, 5000);
    rchk(A_ST, 32'hd);
    wr(A_WDT, wdt_w(4'h6, 1'b0));
    slp <= 1'b1;
    repeat (600) @(posedge clk);
    check(32'(cpu_n), 32'h1);
    slp <= 1'b0;
    // Wake reloads the settings at the next edge; read after it
    @(posedge clk);
    rchk(A_WDT, wdt_w(4'hb, 1'b0));
    wr(A_WDT, wdt_w(4'h6, 1'b1));
    dbg <= 1'b1;
    d = 32'(exc_n);
    repeat (600) @(posedge clk);
    check(32'(exc_n), d);
    dbg <= 1'b0;
    await(2, 1'b1, 300);
    check(32'(cpu_n), 32'h1);
    $display("test watchdog done");
    hold <= 1'b1;
    @(posedge clk);
    hold <= 1'b0;
    await(0, 1'b0, 10);
    await(0, 1'b1, 5000);
    hold <= 1'b1;
    repeat (20) @(posedge clk);
    check(32'({cpu_n, per_n, hs}), 32'h0);
    hold <= 1'b0;
    await(0, 1'b1, 5000);
    por_n <= 1'b0;
    repeat (5) @(posedge clk);
    check(32'(cpu_n), 32'h0);
    por_n <= 1'b1;
    await(0, 1'b1, 5000);
    $display("test pins done");
    for (int m = 1; m < 3; m++) begin
      wr(A_SVM, svm_w(m));
      sup <= 1'b0;
      if (m == 1) await(1, 1'b1, 10);
      repeat (5) @(posedge clk);
      sup <= 1'b1;
      if (m == 2) await(1, 1'b1, 10);
    end
    wr(A_SVM, svm_w(2'h0));
    sup <= 1'b0;
    await(0, 1'b0, 10);
    sup <= 1'b1;
    await(0, 1'b1, 5000);
    $display("test monitor done");
    test_done;
  end
endmodule // test_reset_supervisor_watchdog_lsclk

bind rsw_top rsw_assertions #(.WDT_BASE_CYC(WDT_BASE_CYC)) u_rsw_assertions (
  .mclk(mclk), .rst_n(rst_n), .ext_reset_pin_n(ext_reset_pin_n),
  .power_on_brownout_reset_n(power_on_brownout_reset_n),
  .supply_ok(supply_ok), .lsrc_rc(lsrc_rc), .hsosc_en(hsosc_en),
  .core_reg_en(core_reg_en), .nvm_init(nvm_init), .cpu_rst_n(cpu_rst_n),
  .supply_monitor_en(supply_monitor_en),
  .supply_monitor_irq(supply_monitor_irq), .wdt_exc(wdt_exc),
  .lsclk(lsclk));
